// [logic/exec_pkg.sv]
// Shared constants and types of the complement, adjust, step and divide execution slice.
// Assumes an 8-bit core with byte-wide internal RAM and bank registers held in that RAM.
package exec_pkg;

  // Opcodes handled by this slice
  localparam logic [7:0] OP_CPL_A = 8'hF3;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_DA = 8'hD4;
  localparam logic [7:0] OP_DEC_IND = 8'h16;
  localparam logic [7:0] OP_DEC_A = 8'h14;
  localparam logic [7:0] OP_DEC_REG = 8'h18;
  localparam logic [7:0] OP_DEC_DIR = 8'h15;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_LOOP_COUNT_BRANCH_OP_DIR = 8'hD5;
  localparam logic [7:0] OP_INC_IND = 8'h06;
  localparam logic [7:0] OP_INC_A = 8'h04;
  localparam logic [7:0] OP_INC_POINTER16_REGISTER = 8'hA3;
  localparam logic [7:0] IND_MASK = 8'hFE;
  localparam logic [7:0] REG_MASK = 8'hF8;

  // Machine cycles per instruction and clocks per machine cycle
  localparam int MC_CLKS_DEF = 4;
  localparam int CYC_ONE = 1;
  localparam int CYC_TWO = 2;
  localparam int CYC_DIV = 4;

  // Instruction lengths in bytes
  localparam logic [15:0] LEN1 = 16'h0001;
  localparam logic [15:0] LEN2 = 16'h0002;
  localparam logic [15:0] LEN3 = 16'h0003;

  // Bit address to byte address mapping
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hF8;

  // Decimal adjust constants
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;

  typedef enum {S_IDLE, S_PTR, S_RD, S_WR, S_DIV, S_WAIT} state_t;

  typedef enum {K_NONE, K_CPL_A, K_CPL_C, K_CPL_BIT, K_DA, K_DEC_IND, K_DEC_A, K_DEC_REG,
    K_DEC_DIR, K_DIV, K_LOOP_COUNT_BRANCH_OP, K_INC_IND, K_INC_A, K_INC_POINTER16_REGISTER} op_kind_t;

  function automatic op_kind_t decode(input logic [7:0] op);
    op_kind_t k;
    k = K_NONE;
    if (op == OP_CPL_A) k = K_CPL_A;
    else if (op == OP_CPL_C) k = K_CPL_C;
    else if (op == OP_CPL_BIT) k = K_CPL_BIT;
    else if (op == OP_DA) k = K_DA;
    else if ((op & IND_MASK) == OP_DEC_IND) k = K_DEC_IND;
    else if (op == OP_DEC_A) k = K_DEC_A;
    else if ((op & REG_MASK) == OP_DEC_REG) k = K_DEC_REG;
    else if (op == OP_DEC_DIR) k = K_DEC_DIR;
    else if (op == OP_DIV) k = K_DIV;
    else if (op == OP_LOOP_COUNT_BRANCH_OP_DIR) k = K_LOOP_COUNT_BRANCH_OP;
    else if ((op & IND_MASK) == OP_INC_IND) k = K_INC_IND;
    else if (op == OP_INC_A) k = K_INC_A;
    else if (op == OP_INC_POINTER16_REGISTER) k = K_INC_POINTER16_REGISTER;
    return k;
  endfunction : decode

endpackage : exec_pkg

// [logic/bcd_adjust.sv]
// Combinational decimal adjust of the accumulator after a packed-BCD add.
// Assumes the caller registers the result; nothing here is stored.
`timescale 1ns/1ps
module bcd_adjust (
  input wire logic [7:0] accIn,
  input wire logic carryIn,
  input wire logic halfIn,
  output logic [7:0] accOut,
  output logic carryOut
);
  logic lowFix;
  logic highFix;
  logic midCarry;
  logic [8:0] lowSum;
  logic [8:0] highSum;

  always_comb begin
    lowFix = halfIn || (accIn[3:0] > exec_pkg::BCD_DIGIT_MAX);
    lowSum = {1'b0, accIn} + (lowFix ? {1'b0, exec_pkg::BCD_LOW_FIX} : 9'h000);
    // Carry counts whether it was set before or after the low fix
    midCarry = carryIn || lowSum[8];
    highFix = midCarry || (lowSum[7:4] > exec_pkg::BCD_DIGIT_MAX);
    highSum = {1'b0, lowSum[7:0]} + (highFix ? {1'b0, exec_pkg::BCD_HIGH_FIX} : 9'h000);
    accOut = highSum[7:0];
    carryOut = midCarry || highSum[8];
  end
endmodule : bcd_adjust

// [logic/unsigned_divider.sv]
// Iterative restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse while not running; done pulses W+1 clocks later.
`timescale 1ns/1ps
module unsigned_divider #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic done,
  output logic [W-1:0] quotient,
  output logic [W-1:0] remainder
);
  localparam int CW = $clog2(W + 1);
  logic running;
  logic [CW-1:0] steps;
  logic [W:0] rem;
  logic [W-1:0] quo;
  logic [W-1:0] den;
  logic [W:0] trial;

  assign trial = {rem[W-1:0], quo[W-1]} - {1'b0, den};
  assign done = running && (steps == '0);
  assign quotient = quo;
  assign remainder = rem[W-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      steps <= '0;
      rem <= '0;
      quo <= '0;
      den <= '0;
    end else if (start) begin
      running <= 1'b1;
      steps <= CW'(W);
      rem <= '0;
      quo <= dividend;
      den <= divisor;
    end else if (done) begin
      running <= 1'b0;
    end else if (running) begin
      steps <= steps - 1'b1;
      // A borrow means the trial failed and the shifted remainder is kept
      if (!trial[W]) begin
        rem <= trial;
        quo <= {quo[W-2:0], 1'b1};
      end else begin
        rem <= {rem[W-1:0], quo[W-1]};
        quo <= {quo[W-2:0], 1'b0};
      end
    end
  end
endmodule : unsigned_divider

// [logic/complement_adjust_step_divide_exec.sv]
// Execution slice for complement, decimal adjust, increment, decrement, divide and
// decrement-and-branch. Assumes a same-clock RAM port with combinational read data.
`timescale 1ns/1ps
module complement_adjust_step_divide_exec #(
  parameter int MC_CLKS = exec_pkg::MC_CLKS_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] pcIn,
  input wire logic [1:0] bankSel,
  input wire logic load,
  input wire logic [7:0] accIn,
  input wire logic [7:0] auxIn,
  input wire logic carryIn,
  input wire logic halfCarryIn,
  input wire logic excessIn,
  input wire logic [15:0] pointerIn,
  output logic [7:0] memAddr,
  input wire logic [7:0] memRdData,
  output logic memWrEn,
  output logic [7:0] memWrData,
  output logic busy,
  output logic done,
  output logic reject,
  output logic [15:0] newPc,
  output logic [7:0] acc,
  output logic [7:0] quotient_pair_aux,
  output logic carry,
  output logic half_carry_flag,
  output logic signed_excess_flag,
  output logic [15:0] pointer16_register
);
  // Clocks minus one for each machine-cycle count
  localparam logic [7:0] ONE_CLKS = 8'(MC_CLKS * exec_pkg::CYC_ONE - 1);
  localparam logic [7:0] TWO_CLKS = 8'(MC_CLKS * exec_pkg::CYC_TWO - 1);
  localparam logic [7:0] DIV_CLKS = 8'(MC_CLKS * exec_pkg::CYC_DIV - 1);

  exec_pkg::state_t st;
  exec_pkg::op_kind_t kind;
  exec_pkg::op_kind_t curKind;
  logic accept;
  logic [7:0] remain;
  logic [2:0] bitIdx;
  logic [7:0] offset;
  logic [15:0] pcCap;
  logic [7:0] divisorCap;
  logic [7:0] bcdAcc;
  logic bcdCarry;
  logic divDone;
  logic [7:0] divQuo;
  logic [7:0] divRem;
  logic divZero;
  logic [7:0] stepDown;
  logic [7:0] next_wrData;

  assign kind = exec_pkg::decode(opcode);
  assign accept = start && (st == exec_pkg::S_IDLE) && (kind != exec_pkg::K_NONE);
  assign reject = start && (st == exec_pkg::S_IDLE) && (kind == exec_pkg::K_NONE);
  assign busy = (st != exec_pkg::S_IDLE);
  assign done = (st == exec_pkg::S_WAIT) && (remain == 8'h00);
  assign memWrEn = (st == exec_pkg::S_WR);
  assign divZero = (divisorCap == 8'h00);
  assign stepDown = memRdData - 8'h01;

  bcd_adjust u_bcd (
    .accIn(acc),
    .carryIn(carry),
    .halfIn(half_carry_flag),
    .accOut(bcdAcc),
    .carryOut(bcdCarry)
  );

  unsigned_divider #(.W(8)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(accept && (kind == exec_pkg::K_DIV)),
    .dividend(acc),
    .divisor(quotient_pair_aux),
    .done(divDone),
    .quotient(divQuo),
    .remainder(divRem)
  );

  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= exec_pkg::S_IDLE;
    end else begin
      case (st)
        exec_pkg::S_IDLE: begin
          if (accept) begin
            case (kind)
              exec_pkg::K_DEC_IND, exec_pkg::K_INC_IND: st <= exec_pkg::S_PTR;
              exec_pkg::K_DEC_REG, exec_pkg::K_DEC_DIR, exec_pkg::K_CPL_BIT,
              exec_pkg::K_LOOP_COUNT_BRANCH_OP: st <= exec_pkg::S_RD;
              exec_pkg::K_DIV: st <= exec_pkg::S_DIV;
              default: st <= exec_pkg::S_WAIT;
            endcase
          end
        end
        exec_pkg::S_PTR: st <= exec_pkg::S_RD;
        exec_pkg::S_RD: st <= exec_pkg::S_WR;
        exec_pkg::S_WR: st <= exec_pkg::S_WAIT;
        exec_pkg::S_DIV: begin
          if (divDone) begin
            st <= exec_pkg::S_WAIT;
          end
        end
        exec_pkg::S_WAIT: begin
          if (remain == 8'h00) begin
            st <= exec_pkg::S_IDLE;
          end
        end
        default: st <= exec_pkg::S_IDLE;
      endcase
    end
  end

  // Machine cycle count; memory steps need MC_CLKS of at least four
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= 8'h00;
    end else if (accept) begin
      case (kind)
        exec_pkg::K_DIV: remain <= DIV_CLKS;
        exec_pkg::K_LOOP_COUNT_BRANCH_OP, exec_pkg::K_INC_POINTER16_REGISTER: remain <= TWO_CLKS;
        default: remain <= ONE_CLKS;
      endcase
    end else if (busy && (remain != 8'h00)) begin
      remain <= remain - 8'h01;
    end
  end

  // Captured operands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      curKind <= exec_pkg::K_NONE;
      bitIdx <= 3'h0;
      offset <= 8'h00;
      pcCap <= 16'h0000;
      divisorCap <= 8'h00;
    end else if (accept) begin
      curKind <= kind;
      bitIdx <= operand1[2:0];
      offset <= operand2;
      pcCap <= pcIn;
      divisorCap <= quotient_pair_aux;
    end
  end

  // RAM address: pointer register, bank register, direct byte or bit byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAddr <= 8'h00;
    end else if (accept) begin
      case (kind)
        exec_pkg::K_DEC_IND, exec_pkg::K_INC_IND: memAddr <= {3'b000, bankSel, 2'b00, opcode[0]};
        exec_pkg::K_DEC_REG: memAddr <= {3'b000, bankSel, opcode[2:0]};
        exec_pkg::K_CPL_BIT: begin
          if (operand1[7]) begin
            memAddr <= operand1 & exec_pkg::BIT_SFR_MASK;
          end else begin
            memAddr <= exec_pkg::BIT_AREA_BASE + {4'h0, operand1[6:3]};
          end
        end
        default: memAddr <= operand1;
      endcase
    end else if (st == exec_pkg::S_PTR) begin
      // pointer fetched from R0 or R1
      // pointer fetched from R0 or R1
      memAddr <= memRdData;
    end
  end

  // Read-modify-write data, wrapping modulo 256
  always_comb begin
    case (curKind)
      exec_pkg::K_INC_IND: next_wrData = memRdData + 8'h01;
      exec_pkg::K_CPL_BIT: next_wrData = memRdData ^ (8'h01 << bitIdx);
      default: next_wrData = stepDown;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memWrData <= 8'h00;
    end else if (st == exec_pkg::S_RD) begin
      memWrData <= next_wrData;
    end
  end

  // Next program counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      newPc <= 16'h0000;
    end else if (accept) begin
      case (kind)
        exec_pkg::K_LOOP_COUNT_BRANCH_OP: newPc <= pcIn + exec_pkg::LEN3;
        exec_pkg::K_CPL_BIT, exec_pkg::K_DEC_DIR: newPc <= pcIn + exec_pkg::LEN2;
        default: newPc <= pcIn + exec_pkg::LEN1;
      endcase
    end else if ((st == exec_pkg::S_RD) && (curKind == exec_pkg::K_LOOP_COUNT_BRANCH_OP) &&
                 (stepDown != 8'h00)) begin
      newPc <= newPc + {{8{offset[7]}}, offset};
    end
  end

  // Accumulator, auxiliary register, flags and pointer; start beats a load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 8'h00;
      quotient_pair_aux <= 8'h00;
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      signed_excess_flag <= 1'b0;
      pointer16_register <= 16'h0000;
    end else if (accept) begin
      case (kind)
        exec_pkg::K_CPL_A: acc <= ~acc;
        exec_pkg::K_CPL_C: carry <= ~carry;
        exec_pkg::K_DA: begin
          acc <= bcdAcc;
          carry <= bcdCarry;
        end
        exec_pkg::K_DEC_A: acc <= acc - 8'h01;
        exec_pkg::K_INC_A: acc <= acc + 8'h01;
        exec_pkg::K_INC_POINTER16_REGISTER: pointer16_register <= pointer16_register + 16'h0001;
        default: acc <= acc;
      endcase
    end else if ((st == exec_pkg::S_DIV) && divDone) begin
      carry <= 1'b0;
      signed_excess_flag <= divZero;
      // Zero divisor leaves both operands as they were
      if (!divZero) begin
        acc <= divQuo;
        quotient_pair_aux <= divRem;
      end
    end else if (load && !start && (st == exec_pkg::S_IDLE)) begin
      acc <= accIn;
      quotient_pair_aux <= auxIn;
      carry <= carryIn;
      half_carry_flag <= halfCarryIn;
      signed_excess_flag <= excessIn;
      pointer16_register <= pointerIn;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_CPL_A: assert property (accept && kind == exec_pkg::K_CPL_A |=>
    acc == ~$past(acc) && done == 1'b0)
    else $error("accumulator not inverted");

  AST_CPL_C: assert property (accept && kind == exec_pkg::K_CPL_C |=>
    carry != $past(carry) ##3 done)
    else $error("carry not toggled in one cycle");

  AST_CPL_BIT: assert property (memWrEn && curKind == exec_pkg::K_CPL_BIT |->
    (memWrData ^ $past(memRdData)) == (8'h01 << bitIdx))
    else $error("bit complement changed wrong bits");

  AST_DA_LOW: assert property (accept && kind == exec_pkg::K_DA && !carry &&
    !half_carry_flag && acc[3:0] <= 4'h9 && acc[7:4] <= 4'h9 |=> acc == $past(acc))
    else $error("decimal adjust altered a valid BCD byte");

  AST_DA_CARRY: assert property (accept && kind == exec_pkg::K_DA && carry &&
    acc <= 8'h39 |=> carry && acc[7:4] <= 4'h9)
    else $error("decimal adjust lost carry");

  AST_STEP_DOWN: assert property (memWrEn && (curKind == exec_pkg::K_DEC_IND ||
    curKind == exec_pkg::K_DEC_REG || curKind == exec_pkg::K_DEC_DIR ||
    curKind == exec_pkg::K_LOOP_COUNT_BRANCH_OP) |-> memWrData == $past(memRdData) - 8'h01)
    else $error("memory decrement wrong");

  AST_DEC_A: assert property (accept && kind == exec_pkg::K_DEC_A |=>
    acc == $past(acc) - 8'h01 && carry == $past(carry) &&
    half_carry_flag == $past(half_carry_flag))
    else $error("accumulator decrement wrong");

  AST_REG_ADDR: assert property (st == exec_pkg::S_RD && curKind == exec_pkg::K_DEC_REG |->
    memAddr[2:0] == $past(opcode[2:0]))
    else $error("bank register address wrong");

  AST_DEC_DIR_TIME: assert property (accept && kind == exec_pkg::K_DEC_DIR |->
    ##2 memWrEn ##2 done)
    else $error("direct decrement timing wrong");

  AST_DIV_TIME: assert property (accept && kind == exec_pkg::K_DIV |->
    ##16 done)
    else $error("divide not done in four cycles");

  AST_DIV_FLAGS: assert property (done && curKind == exec_pkg::K_DIV |->
    !carry && signed_excess_flag == divZero)
    else $error("divide flags wrong");

  AST_LOOP_COUNT_BRANCH_OP_TIME: assert property (accept && kind == exec_pkg::K_LOOP_COUNT_BRANCH_OP |->
    ##8 done)
    else $error("loop branch not done in two cycles");

  AST_LOOP_COUNT_BRANCH_OP_PC: assert property (done && curKind == exec_pkg::K_LOOP_COUNT_BRANCH_OP |->
    newPc == pcCap + exec_pkg::LEN3 + ((memWrData != 8'h00) ? {{8{offset[7]}}, offset} : 16'h0000))
    else $error("loop branch target wrong");

  AST_STEP_UP: assert property (memWrEn && curKind == exec_pkg::K_INC_IND |->
    memWrData == $past(memRdData) + 8'h01)
    else $error("memory increment wrong");

  AST_INC_A: assert property (accept && kind == exec_pkg::K_INC_A |=>
    acc == $past(acc) + 8'h01 && signed_excess_flag == $past(signed_excess_flag))
    else $error("accumulator increment wrong");

  AST_POINTER16_REGISTER: assert property (accept && kind == exec_pkg::K_INC_POINTER16_REGISTER |=>
    pointer16_register == $past(pointer16_register) + 16'h0001 ##7 done)
    else $error("pointer increment wrong");

  AST_FLAGS_KEPT: assert property (busy && curKind != exec_pkg::K_DIV &&
    curKind != exec_pkg::K_DA && curKind != exec_pkg::K_CPL_C |=> $stable(carry))
    else $error("step changed carry");

  COV_DIV: cover property (done && curKind == exec_pkg::K_DIV && !divZero);
  COV_DIV_ZERO: cover property (done && curKind == exec_pkg::K_DIV && divZero);
  COV_LOOP_COUNT_BRANCH_OP_TAKEN: cover property (done && curKind == exec_pkg::K_LOOP_COUNT_BRANCH_OP && memWrData != 8'h00);
  COV_DA_CARRY: cover property (accept && kind == exec_pkg::K_DA ##1 carry);

endmodule : complement_adjust_step_divide_exec

// [test/complement_adjust_step_divide_exec_tb_top.sv]
// Self-checking bench for the complement, adjust, step and divide slice.
// Assumes a same-clock RAM with combinational read, modelled here as an array.
`timescale 1ns/1ps
module complement_adjust_step_divide_exec_tb_top;
  localparam int MC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic load = 1'b0;
  logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00, accIn = 8'h00, auxIn = 8'h00;
  logic [15:0] pcIn = 16'h0000, pointerIn = 16'h0000;
  logic [1:0] bankSel = 2'h0;
  logic carryIn = 1'b0, halfCarryIn = 1'b0, excessIn = 1'b0;
  logic [7:0] memAddr, memRdData, memWrData, acc, quotient_pair_aux;
  logic memWrEn, busy, done, reject, carry, half_carry_flag, signed_excess_flag;
  logic [15:0] newPc, pointer16_register;
  logic [7:0] ram [256];
  logic [7:0] ops [24] = '{8'hF3, 8'hB3, 8'hB2, 8'hD4, 8'h16, 8'h17, 8'h14, 8'h18, 8'h19, 8'h1A,
    8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h15, 8'h84, 8'hD5, 8'h06, 8'h07, 8'h04, 8'hA3, 8'hA5,
    8'h00};
  int xm [256];
  int mA, mB, mC, mH, mV, mP;
  int wrCount = 0;
  int failures = 0;
  int compares = 0;
  int seed = 32'hd9fc3b7a;

  always #5 clk = ~clk;

  complement_adjust_step_divide_exec #(.MC_CLKS(MC)) dut (.clk(clk), .rst_n(rst_n),
    .start(start), .opcode(opcode), .operand1(operand1), .operand2(operand2), .pcIn(pcIn),
    .bankSel(bankSel), .load(load), .accIn(accIn), .auxIn(auxIn), .carryIn(carryIn),
    .halfCarryIn(halfCarryIn), .excessIn(excessIn), .pointerIn(pointerIn), .memAddr(memAddr),
    .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData), .busy(busy), .done(done),
    .reject(reject), .newPc(newPc), .acc(acc), .quotient_pair_aux(quotient_pair_aux),
    .carry(carry), .half_carry_flag(half_carry_flag), .signed_excess_flag(signed_excess_flag),
    .pointer16_register(pointer16_register));

  // Read is combinational, so the RAM sits outside the slice
  assign memRdData = ram[memAddr];
  always @(posedge clk) begin
    if (memWrEn === 1'b1) begin
      ram[memAddr] <= memWrData;
      wrCount <= wrCount + 1;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input int exp);
    compares++;
    if (seen !== 16'(exp)) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, 16'(exp), seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic ld(input int a, input int b, input int c, input int h, input int v, input int p);
    @(posedge clk);
    #1;
    load = 1'b1;
    accIn = 8'(a);
    auxIn = 8'(b);
    carryIn = c[0];
    halfCarryIn = h[0];
    excessIn = v[0];
    pointerIn = 16'(p);
    bankSel = 2'($random(seed));
    mA = a & 255;
    mB = b & 255;
    mC = c & 1;
    mH = h & 1;
    mV = v & 1;
    mP = p & 65535;
    @(posedge clk);
    #1;
    load = 1'b0;
  endtask : ld

  task automatic setm(input int ad, input int val);
    ram[ad] = 8'(val);
    xm[ad] = val & 255;
  endtask : setm

  task automatic run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
      input logic [15:0] pc);
    int n, cyc, ePc, wr0, ad, v, nWr;
    n = 1;
    nWr = 0;
    ad = 0;
    ePc = pc + 1;
    if (op == 8'hF3) mA = ~mA & 255;
    else if (op == 8'hB3) mC = mC ^ 1;
    else if (op == 8'hB2) begin
      ad = o1 < 128 ? 32 + o1 / 8 : o1 & 248;
      xm[ad] = xm[ad] ^ (1 << (o1 % 8));
      ePc = pc + 2;
      nWr = 1;
    end else if (op == 8'hD4) begin
      v = mA;
      if (mH != 0 || (v & 15) > 9) v = v + 6;
      if (mC != 0 || v > 255 || ((v >> 4) & 15) > 9) begin
        v = v + 96;
        mC = 1;
      end
      mA = v & 255;
    end else if ((op & 8'hEE) == 8'h06) begin
      ad = xm[bankSel * 8 + op[0]];
      xm[ad] = (xm[ad] + (op[4] ? 255 : 1)) & 255;
      nWr = 1;
    end else if (op == 8'h14) mA = (mA + 255) & 255;
    else if (op == 8'h04) mA = (mA + 1) & 255;
    else if ((op & 8'hF8) == 8'h18 || op == 8'h15 || op == 8'hD5) begin
      ad = op == 8'h18 || op[3] ? bankSel * 8 + op[2:0] : o1;
      xm[ad] = (xm[ad] + 255) & 255;
      nWr = 1;
      if (op == 8'h15) ePc = pc + 2;
      if (op == 8'hD5) begin
        n = 2;
        ePc = pc + 3;
        if (xm[ad] != 0) ePc = ePc + $signed(o2);
      end
    end else if (op == 8'h84) begin
      n = 4;
      mC = 0;
      mV = mB == 0 ? 1 : 0;
      if (mB != 0) begin
        v = mA;
        mA = v / mB;
        mB = v % mB;
      end
    end else if (op == 8'hA3) begin
      n = 2;
      mP = (mP + 1) & 65535;
    end else n = 0;
    wr0 = wrCount;
    @(posedge clk);
    #1;
    start = 1'b1;
    opcode = op;
    operand1 = o1;
    operand2 = o2;
    pcIn = pc;
    @(negedge clk);
    chk("reject", reject, n == 0);
    @(posedge clk);
    #1;
    start = 1'b0;
    cyc = 0;
    if (n != 0) begin
      do begin
        @(negedge clk);
        cyc++;
      end while (done !== 1'b1 && cyc < 40);
      chk("cycles", cyc, MC * n);
      chk("newPc", newPc, ePc & 65535);
      chk("ram", ram[ad], xm[ad]);
    end else begin
      @(negedge clk);
      chk("busy", busy, 0);
    end
    chk("acc", acc, mA);
    chk("aux", quotient_pair_aux, mB);
    chk("carry", carry, mC);
    chk("half", half_carry_flag, mH);
    chk("excess", signed_excess_flag, mV);
    chk("pointer", pointer16_register, mP);
    chk("writes", wrCount - wr0, nWr);
  endtask : run

  initial begin
    #500000;
    failures++;
    complete_run();
  end

  initial begin
    for (int i = 0; i < 256; i++) setm(i, $random(seed));
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    ld(8'h9B, 0, 0, 0, 0, 16'h09FF);
    run(8'hD4, 8'h00, 8'h00, 16'h0100);
    chk("adjAcc", acc, 8'h01);
    chk("adjCarry", carry, 1);
    ld(8'h32, 0, 1, 1, 0, 16'h0000);
    run(8'hD4, 8'h00, 8'h00, 16'h0100);
    chk("adjHigh", acc, 8'h98);
    ld(8'h45, 0, 0, 0, 0, 16'h0000);
    run(8'hD4, 8'h00, 8'h00, 16'h0100);
    chk("adjKeep", acc, 8'h45);
    ld(8'h76, 8'h05, 1, 1, 1, 16'h09FF);
    run(8'h84, 8'h00, 8'h00, 16'h0200);
    chk("quot", acc, 8'h17);
    chk("rem", quotient_pair_aux, 8'h03);
    ld(8'h76, 0, 1, 0, 0, 16'hFFFF);
    run(8'h84, 8'h00, 8'h00, 16'h0200);
    // carry into high byte and wrap
    run(8'hA3, 8'h00, 8'h00, 16'h0300);
    chk("ptrWrap", pointer16_register, 16'h0000);
    ld(8'hFF, 0, 1, 1, 1, 16'h09FF);
    run(8'hA3, 8'h00, 8'h00, 16'h0300);
    chk("ptrCarry", pointer16_register, 16'h0A00);
    run(8'h04, 8'h00, 8'h00, 16'hFFFF);
    run(8'h14, 8'h00, 8'h00, 16'h0010);
    // backward branch, then fall through on zero
    setm(8'h57, 8'h77);
    run(8'hD5, 8'h57, 8'hCA, 16'h00DC);
    chk("loopPc", newPc, 16'h00A9);
    setm(8'h57, 8'h01);
    run(8'hD5, 8'h57, 8'hCA, 16'h00DC);
    chk("fallPc", newPc, 16'h00DF);
    // low bit area and high special area
    run(8'hB2, 8'h0F, 8'h00, 16'h0400);
    run(8'hB2, 8'hE5, 8'h00, 16'h0400);
    // Back to back, every code once, no reload between
    for (int i = 0; i < 24; i++) run(ops[i], 8'($random(seed)), 8'($random(seed)), 16'h1234);
    for (int i = 0; i < 300; i++) begin
      ld($random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed));
      run(ops[($random(seed) & 32'h7FFFFFFF) % 24], 8'($random(seed)), 8'($random(seed)),
        16'($random(seed)));
    end
    complete_run();
  end
endmodule : complement_adjust_step_divide_exec_tb_top
